//--- rtl/cood_pkg.sv
// Constants for the communication object dictionary block
package cood_pkg;
  // Dictionary indices
  localparam logic [15:0] IDX_DEV_KIND   = 16'h1000;
  localparam logic [15:0] IDX_FAULT_CAT  = 16'h1001;
  localparam logic [15:0] IDX_FAULT_HIST = 16'h1003;
  localparam logic [15:0] IDX_SYNC_ID    = 16'h1005;
  localparam logic [15:0] IDX_GUARD      = 16'h100c;
  localparam logic [15:0] IDX_LIFE       = 16'h100d;
  localparam logic [15:0] IDX_STORE      = 16'h1010;
  localparam logic [15:0] IDX_DEFAULTS   = 16'h1011;
  localparam logic [15:0] IDX_EMCY_ID    = 16'h1014;
  localparam logic [15:0] IDX_MON_BEAT   = 16'h1016;
  localparam logic [15:0] IDX_PROD_BEAT  = 16'h1017;

  // Sub-index limits
  localparam logic [7:0]  HIST_DEPTH     = 8'h05;
  localparam logic [7:0]  TRIG_MAX_SUB   = 8'h04;
  localparam logic [7:0]  MON_ENTRIES    = 8'h01;

  // Device kind word fields; values arbitrary
  localparam logic [15:0] DEV_PROFILE    = 16'h0000;
  localparam logic [15:0] DEV_ADD_INFO   = 16'h0000;
  localparam int          DEV_PROFILE_LSB = 0;
  localparam int          DEV_ADD_LSB     = 16;

  // Fault category bit positions
  localparam int          CAT_GENERIC    = 0;
  localparam int          CAT_CURRENT    = 1;
  localparam int          CAT_VOLTAGE    = 2;
  localparam int          CAT_TEMP       = 3;
  localparam int          CAT_COMM       = 4;
  localparam int          CAT_PROFILE    = 5;
  localparam int          CAT_RESERVED   = 6;
  localparam int          CAT_MANUF      = 7;

  // Signatures
  localparam logic [31:0] SIG_STORE      = 32'h65766173;
  localparam logic [31:0] SIG_DEFAULTS   = 32'h64616f6c;
  // Capability word: bit 0 means group handled on command
  localparam logic [31:0] CAP_WORD       = 32'h00000001;

  // Monitor word layout
  localparam int          MON_NODE_LSB   = 16;
  localparam int          MON_ZERO_LSB   = 24;

  // Reset values
  localparam logic [31:0] SYNC_ID_RST    = 32'h00000080;
  localparam logic [31:0] EMCY_ID_RST    = 32'h00000080;
  localparam logic [5:0]  GUARD_RST      = 6'h00;
  localparam logic [7:0]  LIFE_RST       = 8'h00;
  localparam logic [31:0] MON_BEAT_RST   = 32'h00000000;
  localparam logic [15:0] PROD_BEAT_RST  = 16'h0000;

  // Timing
  localparam int          CLK_HZ         = 125000000;
  localparam int          MS_PER_S       = 1000;
  localparam int          MS_CYCLES      = CLK_HZ / MS_PER_S;
endpackage

//--- rtl/cood_comm_dictionary.sv
// Communication-profile object dictionary with guarding and heartbeat timers
// Functional notes
// (RULE_01) Device kind word: low half profile number, high half extra info, read-only.
// (RULE_02) Fault category: 8 read-only bits, each set when its class fault occurs.
// (RULE_03) Bit 0 set whenever any fault is present.
// (RULE_04) Bits: 1 current,2 voltage,3 temperature,4 comm,5 profile,6 reserved,7 maker.
// (RULE_05) Newest fault code sits at history sub-index 1, 32-bit read-only.
// (RULE_06) New fault shifts older entries deeper, five kept, count updated.
// (RULE_07) Writing zero to history count erases the whole history.
// (RULE_08) Reading history beyond stored count gives an abort.
// (RULE_09) Guard interval in ms; zero disables guard supervision.
// (RULE_10) Life time is factor times guard interval; zero factor disables it.
// (RULE_11) Store starts only when exact store signature is written.
// (RULE_12) Store sub-index 1 all, 2 comm, 3 application, 4 drive save.
// (RULE_13) Defaults restored only when exact restore signature is written.
// (RULE_14) Restore sub-index 1 all, 2 comm, 3 application, 4 drive restore.
// (RULE_15) Reading a store or restore sub-index returns a capability word.
// (RULE_16) Emergency messages use the writable emergency identifier.
// (RULE_17) Master sets monitor time above the watched node's production period.
// (RULE_18) Monitor word: bits 31-24 zero, 23-16 node-id, 15-0 time.
// (RULE_19) Producer heartbeat period in ms; zero disables production.
// (RULE_20) Missing heartbeat or guard request within its time flags comm fault.
// (RULE_21) Wrong signature write is aborted and leaves memory untouched.
`timescale 1ns/10ps
`default_nettype none
module cood_comm_dictionary #(
  parameter int MS_CYCLES = cood_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Dictionary access from the SDO server
  input  wire logic        od_req_i,
  input  wire logic        od_wr_i,
  input  wire logic [15:0] od_index_i,
  input  wire logic [7:0]  od_sub_i,
  input  wire logic [31:0] od_wdata_i,
  output logic             od_ack_o,
  output logic             od_abort_o,
  output logic [31:0]      od_rdata_o,
  // Fault reporting from drive logic
  input  wire logic        fault_evt_i,
  input  wire logic [31:0] fault_code_i,
  input  wire logic [7:0]  fault_class_i,
  input  wire logic        fault_clear_i,
  // Network events
  input  wire logic        guard_req_i,
  input  wire logic        beat_seen_i,
  input  wire logic [7:0]  beat_node_i,
  // Outputs to the message layer and storage
  output logic [31:0]      sync_id_o,
  output logic [31:0]      emcy_id_o,
  output logic             beat_send_o,
  output logic             life_lost_o,
  output logic             beat_lost_o,
  output logic             store_req_o,
  output logic [2:0]       store_scope_o,
  output logic             restore_req_o,
  output logic [2:0]       restore_scope_o
);

  logic [31:0] hist_reg [5];
  logic [7:0]  hist_cnt_reg;
  logic [7:0]  cat_reg;
  logic [31:0] sync_id_reg;
  logic [31:0] emcy_id_reg;
  logic [5:0]  guard_reg;
  logic [7:0]  life_reg;
  logic [31:0] mon_reg;
  logic [15:0] prod_reg;
  logic [31:0] ms_cnt_reg;
  logic        ms_tick;
  logic [13:0] life_ms_reg;
  logic [15:0] mon_ms_reg;
  logic [15:0] prod_ms_reg;
  logic [13:0] life_limit;
  logic        comm_fault;

  // Access decode
  logic        wr;
  logic        rd;
  logic        is_trig;
  logic        trig_sub_ok;
  logic        hist_clear;
  logic        bad;
  logic [31:0] rdata_next;

  assign wr = od_req_i & od_wr_i;
  assign rd = od_req_i & ~od_wr_i;
  assign is_trig = (od_index_i == cood_pkg::IDX_STORE) || (od_index_i == cood_pkg::IDX_DEFAULTS);
  assign trig_sub_ok = (od_sub_i != 8'h00) && (od_sub_i <= cood_pkg::TRIG_MAX_SUB);
  assign hist_clear = wr && (od_index_i == cood_pkg::IDX_FAULT_HIST) && (od_sub_i == 8'h00)
                      && (od_wdata_i == 32'h00000000); // RULE_07

  // Read mux and refusal decision
  always_comb begin
    rdata_next = 32'h00000000;
    bad = 1'b0;
    case (od_index_i)
      cood_pkg::IDX_DEV_KIND: begin
        rdata_next[cood_pkg::DEV_PROFILE_LSB +: 16] = cood_pkg::DEV_PROFILE; // RULE_01
        rdata_next[cood_pkg::DEV_ADD_LSB +: 16]     = cood_pkg::DEV_ADD_INFO; // RULE_01
        bad = od_wr_i || (od_sub_i != 8'h00);
      end
      cood_pkg::IDX_FAULT_CAT: begin
        rdata_next[7:0] = cat_reg; // RULE_02
        bad = od_wr_i || (od_sub_i != 8'h00);
      end
      cood_pkg::IDX_FAULT_HIST: begin
        if (od_sub_i == 8'h00) begin
          rdata_next[7:0] = hist_cnt_reg;
          // Only zero is a legal count write
          bad = od_wr_i && (od_wdata_i != 32'h00000000); // RULE_07
        end else begin
          bad = od_wr_i || (od_sub_i > hist_cnt_reg); // RULE_08
          if (od_sub_i <= cood_pkg::HIST_DEPTH) begin
            rdata_next = hist_reg[3'(od_sub_i - 8'h01)]; // RULE_05
          end
        end
      end
      cood_pkg::IDX_SYNC_ID: begin
        rdata_next = sync_id_reg;
        bad = (od_sub_i != 8'h00);
      end
      cood_pkg::IDX_GUARD: begin
        rdata_next[5:0] = guard_reg;
        bad = (od_sub_i != 8'h00);
      end
      cood_pkg::IDX_LIFE: begin
        rdata_next[7:0] = life_reg;
        bad = (od_sub_i != 8'h00);
      end
      cood_pkg::IDX_STORE, cood_pkg::IDX_DEFAULTS: begin
        if (od_sub_i == 8'h00) begin
          rdata_next[7:0] = cood_pkg::TRIG_MAX_SUB;
          bad = od_wr_i;
        end else if (trig_sub_ok) begin
          rdata_next = cood_pkg::CAP_WORD; // RULE_15
          if (od_index_i == cood_pkg::IDX_STORE) begin
            bad = od_wr_i && (od_wdata_i != cood_pkg::SIG_STORE); // RULE_11 RULE_21
          end else begin
            bad = od_wr_i && (od_wdata_i != cood_pkg::SIG_DEFAULTS); // RULE_13 RULE_21
          end
        end else begin
          bad = 1'b1;
        end
      end
      cood_pkg::IDX_EMCY_ID: begin
        rdata_next = emcy_id_reg;
        bad = (od_sub_i != 8'h00);
      end
      cood_pkg::IDX_MON_BEAT: begin
        if (od_sub_i == 8'h00) begin
          rdata_next[7:0] = cood_pkg::MON_ENTRIES;
          bad = od_wr_i;
        end else if (od_sub_i == cood_pkg::MON_ENTRIES) begin
          rdata_next = mon_reg;
          // Upper byte must stay zero
          bad = od_wr_i && (od_wdata_i[31:cood_pkg::MON_ZERO_LSB] != 8'h00); // RULE_18
        end else begin
          bad = 1'b1;
        end
      end
      cood_pkg::IDX_PROD_BEAT: begin
        rdata_next[15:0] = prod_reg;
        bad = (od_sub_i != 8'h00);
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  // Answer one cycle after the request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      od_ack_o   <= 1'b0;
      od_abort_o <= 1'b0;
      od_rdata_o <= 32'h00000000;
    end else begin
      od_ack_o   <= od_req_i;
      od_abort_o <= od_req_i & bad; // RULE_08 RULE_21
      od_rdata_o <= (rd && !bad) ? rdata_next : 32'h00000000;
    end
  end

  // Writable communication entries; refused writes leave them alone
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_id_reg <= cood_pkg::SYNC_ID_RST;
    end else if (wr && !bad && od_index_i == cood_pkg::IDX_SYNC_ID) begin
      sync_id_reg <= od_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      emcy_id_reg <= cood_pkg::EMCY_ID_RST;
    end else if (wr && !bad && od_index_i == cood_pkg::IDX_EMCY_ID) begin
      emcy_id_reg <= od_wdata_i; // RULE_16
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      guard_reg <= cood_pkg::GUARD_RST;
    end else if (wr && !bad && od_index_i == cood_pkg::IDX_GUARD) begin
      guard_reg <= od_wdata_i[5:0]; // RULE_09
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      life_reg <= cood_pkg::LIFE_RST;
    end else if (wr && !bad && od_index_i == cood_pkg::IDX_LIFE) begin
      life_reg <= od_wdata_i[7:0]; // RULE_10
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mon_reg <= cood_pkg::MON_BEAT_RST;
    end else if (wr && !bad && od_index_i == cood_pkg::IDX_MON_BEAT) begin
      mon_reg <= od_wdata_i; // RULE_18
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prod_reg <= cood_pkg::PROD_BEAT_RST;
    end else if (wr && !bad && od_index_i == cood_pkg::IDX_PROD_BEAT) begin
      prod_reg <= od_wdata_i[15:0]; // RULE_19
    end
  end

  assign sync_id_o = sync_id_reg;
  assign emcy_id_o = emcy_id_reg; // RULE_16

  // Store and restore requests; memory itself lives outside
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      store_req_o     <= 1'b0;
      store_scope_o   <= 3'h0;
      restore_req_o   <= 1'b0;
      restore_scope_o <= 3'h0;
    end else begin
      store_req_o   <= wr && !bad && is_trig && trig_sub_ok
                       && (od_index_i == cood_pkg::IDX_STORE); // RULE_11
      restore_req_o <= wr && !bad && is_trig && trig_sub_ok
                       && (od_index_i == cood_pkg::IDX_DEFAULTS); // RULE_13
      if (wr && !bad && is_trig && trig_sub_ok) begin
        if (od_index_i == cood_pkg::IDX_STORE) begin
          store_scope_o <= od_sub_i[2:0]; // RULE_12
        end else begin
          restore_scope_o <= od_sub_i[2:0]; // RULE_14
        end
      end
    end
  end

  // Fault history; a new fault in the clearing cycle survives as entry 1
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hist_cnt_reg <= 8'h00;
      for (int i = 0; i < 5; i++) begin
        hist_reg[i] <= 32'h00000000;
      end
    end else if (fault_evt_i) begin
      hist_reg[0] <= fault_code_i; // RULE_05
      for (int i = 1; i < 5; i++) begin
        hist_reg[i] <= hist_clear ? 32'h00000000 : hist_reg[i-1]; // RULE_06
      end
      if (hist_clear) begin
        hist_cnt_reg <= 8'h01;
      end else if (hist_cnt_reg < cood_pkg::HIST_DEPTH) begin
        hist_cnt_reg <= hist_cnt_reg + 8'h01; // RULE_06
      end
    end else if (hist_clear) begin
      hist_cnt_reg <= 8'h00; // RULE_07
      for (int i = 0; i < 5; i++) begin
        hist_reg[i] <= 32'h00000000;
      end
    end
  end

  // Fault category flags; setting wins over clearing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cat_reg <= 8'h00;
    end else begin
      cat_reg[7:1] <= (fault_clear_i ? 7'h00 : cat_reg[7:1])
                      | (fault_evt_i ? fault_class_i[7:1] : 7'h00) // RULE_02 RULE_04
                      | {3'h0, comm_fault, 3'h0}; // RULE_04 RULE_20
      cat_reg[cood_pkg::CAT_GENERIC] <= (~fault_clear_i & cat_reg[cood_pkg::CAT_GENERIC])
                                        | fault_evt_i | comm_fault; // RULE_03
    end
  end

  // Millisecond base; long count kept as a parameter for simulation
  assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_cnt_reg <= 32'h00000000;
    end else begin
      ms_cnt_reg <= ms_tick ? 32'h00000000 : ms_cnt_reg + 32'h00000001;
    end
  end

  // Life time supervision
  assign life_limit = 14'(guard_reg) * 14'(life_reg); // RULE_10

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      life_ms_reg <= 14'h0000;
      life_lost_o <= 1'b0;
    end else begin
      life_lost_o <= 1'b0;
      if (guard_req_i || guard_reg == 6'h00 || life_reg == 8'h00) begin
        life_ms_reg <= 14'h0000; // RULE_09 RULE_10
      end else if (ms_tick) begin
        if (life_ms_reg + 14'h0001 >= life_limit) begin
          life_lost_o <= 1'b1; // RULE_20
          life_ms_reg <= 14'h0000;
        end else begin
          life_ms_reg <= life_ms_reg + 14'h0001;
        end
      end
    end
  end

  // Consumer heartbeat supervision for the configured node
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mon_ms_reg  <= 16'h0000;
      beat_lost_o <= 1'b0;
    end else begin
      beat_lost_o <= 1'b0;
      if (mon_reg[15:0] == 16'h0000
          || (beat_seen_i && beat_node_i == mon_reg[cood_pkg::MON_NODE_LSB +: 8])) begin
        mon_ms_reg <= 16'h0000; // RULE_18
      end else if (ms_tick) begin
        if (mon_ms_reg + 16'h0001 >= mon_reg[15:0]) begin
          beat_lost_o <= 1'b1; // RULE_20
          mon_ms_reg  <= 16'h0000;
        end else begin
          mon_ms_reg <= mon_ms_reg + 16'h0001;
        end
      end
    end
  end

  assign comm_fault = life_lost_o | beat_lost_o; // RULE_20

  // Heartbeat production
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prod_ms_reg <= 16'h0000;
      beat_send_o <= 1'b0;
    end else begin
      beat_send_o <= 1'b0;
      if (prod_reg == 16'h0000) begin
        prod_ms_reg <= 16'h0000; // RULE_19
      end else if (ms_tick) begin
        if (prod_ms_reg + 16'h0001 >= prod_reg) begin
          beat_send_o <= 1'b1; // RULE_19
          prod_ms_reg <= 16'h0000;
        end else begin
          prod_ms_reg <= prod_ms_reg + 16'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- sim/cood_dict_monitor.sv
// Port-level assertions for the communication object dictionary
`timescale 1ns/10ps
`default_nettype none
module cood_dict_monitor #(
  parameter int MS_CYCLES = 10
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Dictionary access
  input wire logic        od_req_i,
  input wire logic        od_wr_i,
  input wire logic [15:0] od_index_i,
  input wire logic [7:0]  od_sub_i,
  input wire logic [31:0] od_wdata_i,
  input wire logic        od_ack_o,
  input wire logic        od_abort_o,
  // Identifier and storage commands
  input wire logic [31:0] emcy_id_o,
  input wire logic        store_req_o,
  input wire logic [2:0]  store_scope_o,
  input wire logic        restore_req_o,
  input wire logic [2:0]  restore_scope_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr(logic [15:0] ix);
    od_req_i && od_wr_i && od_index_i == ix;
  endsequence
  sequence s_trig(logic [15:0] ix, logic [31:0] sg, logic good);
    s_wr(ix) ##0 (od_sub_i inside {[8'h01:8'h04]} && ((od_wdata_i == sg) == good));
  endsequence
  a_ack_next: assert property (od_req_i |=> od_ack_o)
    else $error("request without answer");
  a_ack_only: assert property (!od_req_i |=> !od_ack_o)
    else $error("answer without request");
  a_abort_ack: assert property (od_abort_o |-> od_ack_o)
    else $error("abort outside answer");
  a_store_sig: assert property (s_trig(16'h1010, 32'h65766173, 1'b1) |=> store_req_o && !od_abort_o)
    else $error("store not started on signature");
  a_store_bad: assert property (s_trig(16'h1010, 32'h65766173, 1'b0) |=> od_abort_o && !store_req_o)
    else $error("store accepted bad signature");
  a_store_scope: assert property (store_req_o |-> store_scope_o == $past(od_sub_i[2:0]))
    else $error("store scope mismatch");
  a_dflt_sig: assert property (s_trig(16'h1011, 32'h64616f6c, 1'b1) |=> restore_req_o && !od_abort_o)
    else $error("restore not started on signature");
  a_dflt_bad: assert property (s_trig(16'h1011, 32'h64616f6c, 1'b0) |=> od_abort_o && !restore_req_o)
    else $error("restore accepted bad signature");
  a_dflt_scope: assert property (restore_req_o |-> restore_scope_o == $past(od_sub_i[2:0]))
    else $error("restore scope mismatch");
  a_kind_ro: assert property (s_wr(16'h1000) |=> od_abort_o)
    else $error("device kind write accepted");
  a_emcy_take: assert property (s_wr(16'h1014) ##0 od_sub_i == 8'h00 |=> emcy_id_o == $past(od_wdata_i))
    else $error("emergency identifier not taken");
  a_beat_top: assert property (s_wr(16'h1016) ##0 (od_sub_i == 8'h01 && od_wdata_i[31:24] != 8'h00) |=> od_abort_o)
    else $error("monitor word top byte accepted");
endmodule
`default_nettype wire

//--- sim/cood_sdo_master.sv
// Network master model issuing dictionary accesses
`timescale 1ns/10ps
`default_nettype none
module cood_sdo_master (
  // Clock
  input  wire logic        clk_i,
  // Request
  output logic             od_req_o,
  output logic             od_wr_o,
  output logic [15:0]      od_index_o,
  output logic [7:0]       od_sub_o,
  output logic [31:0]      od_wdata_o,
  // Answer
  input  wire logic        od_ack_i,
  input  wire logic        od_abort_i,
  input  wire logic [31:0] od_rdata_i
);
  int idle_cyc;
  initial begin
    idle_cyc = 0;
    od_req_o = 1'b0;
    od_wr_o = 1'b0;
    od_index_o = 16'h0000;
    od_sub_o = 8'h00;
    od_wdata_o = 32'h00000000;
  end
  // Signatures come from the caller, only exact words are meant to trigger
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
                      input logic [31:0] d, output logic ab, output logic [31:0] rd);
    int n;
    n = 0;
    repeat (idle_cyc + 1) @(posedge clk_i);
    #1 od_req_o = 1'b1;
    od_wr_o = w;
    od_index_o = i;
    od_sub_o = s;
    od_wdata_o = d;
    @(posedge clk_i);
    #1 od_req_o = 1'b0;
    while (od_ack_i !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      #1 n++;
    end
    ab = od_abort_i;
    rd = od_rdata_i;
    // Released qualifiers must not look like the last request
    od_index_o = ~i;
    od_sub_o = ~s;
    od_wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

//--- sim/tb_canopen_comm_object_dictionary.sv
// Self-checking bench for the communication object dictionary
`timescale 1ns/10ps
`default_nettype none
module tb_canopen_comm_object_dictionary;
  localparam int MS = 10;
  logic        clk_i, rst_i, od_req, od_wr, od_ack, od_abort, ab;
  logic        fault_evt, fault_clear, guard_req, beat_seen;
  logic        beat_send, life_lost, beat_lost, store_req, restore_req;
  logic [15:0] od_index;
  logic [7:0]  od_sub, fault_class, beat_node;
  logic [31:0] od_wdata, od_rdata, fault_code, sync_id, emcy_id, rd;
  logic [2:0]  store_scope, restore_scope;
  int          n_errors, checks, n;
  cood_comm_dictionary #(.MS_CYCLES(MS)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .od_req_i(od_req), .od_wr_i(od_wr), .od_index_i(od_index),
    .od_sub_i(od_sub), .od_wdata_i(od_wdata), .od_ack_o(od_ack), .od_abort_o(od_abort),
    .od_rdata_o(od_rdata), .fault_evt_i(fault_evt), .fault_code_i(fault_code),
    .fault_class_i(fault_class), .fault_clear_i(fault_clear), .guard_req_i(guard_req),
    .beat_seen_i(beat_seen), .beat_node_i(beat_node), .sync_id_o(sync_id), .emcy_id_o(emcy_id),
    .beat_send_o(beat_send), .life_lost_o(life_lost), .beat_lost_o(beat_lost),
    .store_req_o(store_req), .store_scope_o(store_scope), .restore_req_o(restore_req),
    .restore_scope_o(restore_scope));
  cood_sdo_master m_u (
    .clk_i(clk_i), .od_req_o(od_req), .od_wr_o(od_wr), .od_index_o(od_index), .od_sub_o(od_sub),
    .od_wdata_o(od_wdata), .od_ack_i(od_ack), .od_abort_i(od_abort), .od_rdata_i(od_rdata));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] d, input logic ea, input logic [31:0] er);
    m_u.xfer(w, i, s, d, ab, rd);
    chk("ack", 32'h1, {31'h0, od_ack});
    chk("abort", {31'h0, ea}, {31'h0, ab});
    chk("rdata", er, rd);
  endtask
  task automatic pulse(input int w, input logic [31:0] c, input logic [7:0] k);
    @(posedge clk_i);
    #1 {fault_evt, guard_req, beat_seen, fault_clear} = 4'b1000 >> w;
    fault_code = c;
    fault_class = k;
    beat_node = k;
    @(posedge clk_i);
    #1 {fault_evt, guard_req, beat_seen, fault_clear} = 4'b0000;
    fault_code = ~c;
  endtask
  // Counts cycles to the next pulse of one output; lim means none seen
  task automatic wait_for(input int w, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_i);
      #1 cnt++;
    end while ((w == 0 ? life_lost : w == 1 ? beat_lost : beat_send) !== 1'b1 && cnt < lim);
  endtask
  task automatic t_ids;
    acc(1'b0, 16'h1000, 8'h00, 32'h0, 1'b0, {cood_pkg::DEV_ADD_INFO, cood_pkg::DEV_PROFILE});
    acc(1'b1, 16'h1000, 8'h00, 32'h1, 1'b1, 32'h0);
    acc(1'b0, 16'h1234, 8'h00, 32'h0, 1'b1, 32'h0);
    acc(1'b0, 16'h1014, 8'h00, 32'h0, 1'b0, 32'h80);
    m_u.idle_cyc = 3;
    acc(1'b1, 16'h1014, 8'h00, 32'h000000a5, 1'b0, 32'h0);
    m_u.idle_cyc = 0;
    chk("emcy_id", 32'ha5, emcy_id);
    acc(1'b1, 16'h1005, 8'h00, 32'h00000081, 1'b0, 32'h0);
    chk("sync_id", 32'h81, sync_id);
  endtask
  task automatic t_faults;
    acc(1'b0, 16'h1001, 8'h00, 32'h0, 1'b0, 32'h0);
    for (int k = 1; k <= 7; k++)
      pulse(0, 32'h1000 + k, 8'(1 << k));
    acc(1'b0, 16'h1001, 8'h00, 32'h0, 1'b0, 32'hff);
    acc(1'b0, 16'h1003, 8'h00, 32'h0, 1'b0, 32'h5);
    for (int s = 1; s <= 5; s++)
      acc(1'b0, 16'h1003, 8'(s), 32'h0, 1'b0, 32'h1008 - s);
    acc(1'b0, 16'h1003, 8'h06, 32'h0, 1'b1, 32'h0);
    pulse(3, 32'h0, 8'h00);
    pulse(0, 32'h2222, 8'h08);
    acc(1'b0, 16'h1001, 8'h00, 32'h0, 1'b0, 32'h09);
    acc(1'b1, 16'h1003, 8'h00, 32'h1, 1'b1, 32'h0);
    acc(1'b1, 16'h1003, 8'h00, 32'h0, 1'b0, 32'h0);
    acc(1'b0, 16'h1003, 8'h01, 32'h0, 1'b1, 32'h0);
  endtask
  task automatic t_store;
    logic [15:0] ix;
    logic [31:0] sg;
    for (int j = 0; j < 2; j++) begin
      ix = j ? 16'h1011 : 16'h1010;
      sg = j ? cood_pkg::SIG_DEFAULTS : cood_pkg::SIG_STORE;
      acc(1'b0, ix, 8'h00, 32'h0, 1'b0, 32'h4);
      acc(1'b1, ix, 8'h05, sg, 1'b1, 32'h0);
      for (int s = 1; s <= 4; s++) begin
        acc(1'b1, ix, 8'(s), ~sg, 1'b1, 32'h0);
        chk("req_bad", 32'h0, {31'h0, j ? restore_req : store_req});
        acc(1'b1, ix, 8'(s), sg, 1'b0, 32'h0);
        chk("req", 32'h1, {31'h0, j ? restore_req : store_req});
        chk("scope", 32'(s), {29'h0, j ? restore_scope : store_scope});
        acc(1'b0, ix, 8'(s), 32'h0, 1'b0, cood_pkg::CAP_WORD);
      end
    end
  endtask
  task automatic t_life;
    acc(1'b1, 16'h100c, 8'h00, 32'h2, 1'b0, 32'h0);
    acc(1'b1, 16'h100d, 8'h00, 32'h3, 1'b0, 32'h0);
    acc(1'b0, 16'h100c, 8'h00, 32'h0, 1'b0, 32'h2);
    pulse(1, 32'h0, 8'h00);
    wait_for(0, 200, n);
    chk("life_time", 32'h1, 32'(n >= 5 * MS - 5 && n <= 6 * MS + 10));
    acc(1'b0, 16'h1001, 8'h00, 32'h0, 1'b0, 32'h19);
    acc(1'b1, 16'h100d, 8'h00, 32'h0, 1'b0, 32'h0);
    wait_for(0, 150, n);
    chk("life_off", 32'd150, 32'(n));
    acc(1'b1, 16'h100d, 8'h00, 32'h3, 1'b0, 32'h0);
    acc(1'b1, 16'h100c, 8'h00, 32'h0, 1'b0, 32'h0);
    wait_for(0, 150, n);
    chk("guard_off", 32'd150, 32'(n));
  endtask
  task automatic t_beat;
    acc(1'b1, 16'h1016, 8'h01, 32'h01050003, 1'b1, 32'h0);
    acc(1'b1, 16'h1016, 8'h01, 32'h00050003, 1'b0, 32'h0);
    acc(1'b0, 16'h1016, 8'h01, 32'h0, 1'b0, 32'h00050003);
    acc(1'b0, 16'h1016, 8'h00, 32'h0, 1'b0, 32'h1);
    for (int k = 0; k < 6; k++) begin
      pulse(2, 32'h0, 8'h05);
      wait_for(1, 13, n);
      chk("beat_kept", 32'd13, 32'(n));
    end
    pulse(2, 32'h0, 8'h06);
    wait_for(1, 100, n);
    chk("beat_lost", 32'h1, 32'(n >= 2 * MS - 15 && n <= 3 * MS - 15));
    acc(1'b1, 16'h1016, 8'h01, 32'h0, 1'b0, 32'h0);
    acc(1'b1, 16'h1017, 8'h00, 32'h2, 1'b0, 32'h0);
    wait_for(2, 100, n);
    wait_for(2, 100, n);
    chk("beat_period", 32'(2 * MS), 32'(n));
    acc(1'b1, 16'h1017, 8'h00, 32'h0, 1'b0, 32'h0);
    wait_for(2, 100, n);
    chk("beat_off", 32'd100, 32'(n));
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {rst_i, fault_evt, guard_req, beat_seen, fault_clear} = 5'b10000;
    {fault_code, fault_class, beat_node} = 48'h0;
    n_errors = 0;
    checks = 0;
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_ids();
    t_faults();
    t_store();
    t_life();
    t_beat();
    final_report();
  end
  initial begin
    #100000;
    n_errors++;
    $display("[ERR] watchdog expected done seen hang");
    final_report();
  end
endmodule
bind cood_comm_dictionary cood_dict_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (
  .clk_i(clk_i), .rst_i(rst_i), .od_req_i(od_req_i), .od_wr_i(od_wr_i), .od_index_i(od_index_i),
  .od_sub_i(od_sub_i), .od_wdata_i(od_wdata_i), .od_ack_o(od_ack_o), .od_abort_o(od_abort_o),
  .emcy_id_o(emcy_id_o), .store_req_o(store_req_o), .store_scope_o(store_scope_o),
  .restore_req_o(restore_req_o), .restore_scope_o(restore_scope_o));
`default_nettype wire
